// ==== hdl/dsh_pkg.sv ====
// Purpose: constants and types for the dual serial host control port
// Assumes: 100 MHz system clock; device straps and pins wired by the bench
// Notes:   host side; serial clocks are divided down from i_clk_sys
package dsh_pkg;
	localparam int CLK_NS       = 10;
	// four-wire bit clock period
	localparam int SPI_CLK_NS   = 200;
	localparam int SPI_HALF_CYC = (SPI_CLK_NS / 2 + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] SPI_HALF_M1 = 8'(SPI_HALF_CYC - 1);
	localparam logic [3:0] SPI_LAST_BIT = 4'hf;
	localparam logic [3:0] SPI_DATA_BIT = 4'h8;
	// two-wire fast-mode bit period, split in quarters
	localparam int I2C_BIT_NS   = 2500;
	localparam int I2C_QTR_CYC  = (I2C_BIT_NS / 4 + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] I2C_QTR_M1 = 8'(I2C_QTR_CYC - 1);
	localparam logic [4:0] I2C_ADDR_HI = 5'h10;
	localparam logic [3:0] I2C_ACK_BIT = 4'h8;
	localparam logic       DIR_WRITE = 1'b0;
	localparam logic       DIR_READ  = 1'b1;
	localparam logic       MODE_I2C  = 1'b0;
	localparam logic       MODE_SPI  = 1'b1;

	typedef enum logic [4:0] {
		SPI_IDLE  = 5'b00001,
		SPI_SETUP = 5'b00010,
		SPI_LOW   = 5'b00100,
		SPI_HIGH  = 5'b01000,
		SPI_HOLD  = 5'b10000
	} dsh_spi_st_t;

	typedef enum logic [5:0] {
		I2C_IDLE   = 6'b000001,
		I2C_START  = 6'b000010,
		I2C_BIT    = 6'b000100,
		I2C_RSTART = 6'b001000,
		I2C_STOP   = 6'b010000,
		I2C_DONE   = 6'b100000
	} dsh_i2c_st_t;
endpackage

// ==== hdl/dsh_cmd_if.sv ====
// Purpose: command carrier between the host top and the four-wire engine
// Assumes: all signals on i_clk_sys
// Notes:   start is a one-cycle pulse, done a one-cycle pulse
interface dsh_cmd_if;
	logic       start;
	logic       rd;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic       busy;
	logic       done;
	logic [7:0] rdata;

	modport ctl (output start, rd, addr, wdata, input busy, done, rdata);
	modport eng (input start, rd, addr, wdata, output busy, done, rdata);
endinterface

// ==== hdl/dsh_spi_master.sv ====
// Purpose: four-wire frame engine, one 16-bit frame per command
// Assumes: miso arrives already synchronised to i_clk_sys
// Notes:   bit clock idles high; host shifts on fall, samples at end of high
module dsh_spi_master
	import dsh_pkg::*;
(
	// clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_nrst,
	// command side
	dsh_cmd_if.eng    cmd,
	// pins
	input  wire logic i_miso_sync,
	output logic      o_sclk,
	output logic      o_sel_n,
	output logic      o_mosi
);
	dsh_spi_st_t st_r;
	logic [7:0]  cnt_r;
	logic [3:0]  bit_r;
	logic [15:0] sh_r;
	logic [7:0]  rx_r;
	logic        done_r;

	wire half_end = (cnt_r == SPI_HALF_M1);
	wire last_bit = (bit_r == SPI_LAST_BIT);

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			st_r   <= SPI_IDLE;
			cnt_r  <= 8'h00;
			bit_r  <= 4'h0;
			sh_r   <= 16'h0000;
			rx_r   <= 8'h00;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			cnt_r  <= (st_r == SPI_IDLE || half_end) ? 8'h00 : cnt_r + 8'h01;
			case (st_r)
				SPI_IDLE: begin
					bit_r <= 4'h0;
					if (cmd.start) begin
						sh_r <= {cmd.rd, cmd.addr,
							cmd.rd ? 8'hff : cmd.wdata};
						st_r <= SPI_SETUP;
					end
				end
				SPI_SETUP: begin
					if (half_end) begin
						st_r <= SPI_LOW;
					end
				end
				SPI_LOW: begin
					if (half_end) begin
						st_r <= SPI_HIGH;
					end
				end
				SPI_HIGH: begin
					if (half_end) begin
						// data is stable through the high half after the fall
						if (bit_r >= SPI_DATA_BIT) begin
							rx_r <= {rx_r[6:0], i_miso_sync};
						end
						if (last_bit) begin
							st_r <= SPI_HOLD;
						end else begin
							bit_r <= bit_r + 4'h1;
							sh_r  <= {sh_r[14:0], 1'b0};
							st_r  <= SPI_LOW;
						end
					end
				end
				SPI_HOLD: begin
					if (half_end) begin
						st_r   <= SPI_IDLE;
						done_r <= 1'b1;
					end
				end
				default: begin
					st_r <= SPI_IDLE;
				end
			endcase
		end
	end

	// divided clock, idles high; no second domain
	assign o_sclk    = (st_r != SPI_LOW);
	assign o_sel_n   = (st_r == SPI_IDLE);
	assign o_mosi    = sh_r[15];
	assign cmd.busy  = (st_r != SPI_IDLE);
	assign cmd.done  = done_r;
	assign cmd.rdata = rx_r;
endmodule

// ==== hdl/dsh_host.sv ====
// Purpose: host controller for the dual serial control port of the device
// Assumes: bench resolves open-drain wires from the active-low enables
// Notes:   mode strap fixed at reset; one register access per command
module dsh_host
	import dsh_pkg::*;
(
	// clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_nrst,
	// configuration
	input  wire logic       i_mode_spi,
	input  wire logic [1:0] i_dev_sel,
	output logic            o_mode_strap,
	// command port
	input  wire logic       i_req,
	input  wire logic       i_rd,
	input  wire logic [6:0] i_addr,
	input  wire logic [7:0] i_wdata,
	output logic            o_ready,
	output logic            o_done,
	output logic [7:0]      o_rdata,
	output logic            o_nack,
	// four-wire pins
	output logic            o_ctrl_bit_clock,
	output logic            o_ctrl_select_n,
	output logic            o_ctrl_serial_in,
	input  wire logic       i_ctrl_serial_out,
	// two-wire pins
	input  wire logic       i_scl,
	output logic            o_scl,
	output logic            o_scl_oe_n,
	input  wire logic       i_sda,
	output logic            o_sda,
	output logic            o_sda_oe_n,
	// interrupt pins
	input  wire logic       i_error_or_irq_a_pin,
	input  wire logic       i_nonlinear_or_irq_b_pin,
	output logic            o_irq_channel_a,
	output logic            o_irq_channel_b
);
	// byte placed on the wire for each step of a two-wire access
	function automatic logic [7:0] i2c_byte(input logic [1:0] step,
		input logic rd, input logic [6:0] dev,
		input logic [7:0] reg_addr, input logic [7:0] wdata);
		logic [7:0] b;
		b = 8'hff;
		case (step)
			2'h0: b = {dev, DIR_WRITE};
			2'h1: b = reg_addr;
			2'h2: b = rd ? {dev, DIR_READ} : wdata;
			default: b = 8'hff;
		endcase
		return b;
	endfunction

	// mode strap and capture
	logic mode_r;
	logic cap_done_r;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			mode_r     <= MODE_I2C;
			cap_done_r <= 1'b0;
		end else if (!cap_done_r) begin
			mode_r     <= i_mode_spi;
			cap_done_r <= 1'b1;
		end
	end

	assign o_mode_strap = mode_r;

	// pin synchronisers
	logic [1:0] miso_s_r;
	logic [1:0] scl_s_r;
	logic [1:0] sda_s_r;
	logic [1:0] irqa_s_r;
	logic [1:0] irqb_s_r;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			miso_s_r <= 2'h0;
			scl_s_r  <= 2'h3;
			sda_s_r  <= 2'h3;
			irqa_s_r <= 2'h0;
			irqb_s_r <= 2'h0;
		end else begin
			miso_s_r <= {miso_s_r[0], i_ctrl_serial_out};
			scl_s_r  <= {scl_s_r[0], i_scl};
			sda_s_r  <= {sda_s_r[0], i_sda};
			irqa_s_r <= {irqa_s_r[0], i_error_or_irq_a_pin};
			irqb_s_r <= {irqb_s_r[0], i_nonlinear_or_irq_b_pin};
		end
	end

	wire miso_q = miso_s_r[1];
	wire scl_q  = scl_s_r[1];
	wire sda_q  = sda_s_r[1];

	// renewal and error causes come out on the shared irq pins
	assign o_irq_channel_a = irqa_s_r[1];
	assign o_irq_channel_b = irqb_s_r[1];

	// command routing
	dsh_cmd_if spi_cmd();

	logic        i2c_busy;
	logic        i2c_done_r;
	logic [7:0]  i2c_rx_r;
	logic        i2c_nack_r;
	logic        rd_r;
	logic [6:0]  addr_r;
	logic [7:0]  wdata_r;
	logic [7:0]  rdata_r;
	logic        nack_r;

	wire take      = i_req & o_ready;
	wire take_spi  = take & (mode_r == MODE_SPI);
	wire take_i2c  = take & (mode_r == MODE_I2C);
	wire any_done  = spi_cmd.done | i2c_done_r;

	assign o_ready = cap_done_r & ~spi_cmd.busy & ~i2c_busy;

	assign spi_cmd.start = take_spi;
	assign spi_cmd.rd    = i_rd;
	assign spi_cmd.addr  = i_addr;
	assign spi_cmd.wdata = i_wdata;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			rd_r    <= 1'b0;
			addr_r  <= 7'h00;
			wdata_r <= 8'h00;
			rdata_r <= 8'h00;
			nack_r  <= 1'b0;
		end else begin
			if (take) begin
				rd_r    <= i_rd;
				addr_r  <= i_addr;
				wdata_r <= i_wdata;
			end
			if (spi_cmd.done) begin
				rdata_r <= rd_r ? spi_cmd.rdata : 8'h00;
				nack_r  <= 1'b0;
			end else if (i2c_done_r) begin
				rdata_r <= i2c_rx_r;
				nack_r  <= i2c_nack_r;
			end
		end
	end

	assign o_done  = any_done;
	assign o_rdata = rdata_r;
	assign o_nack  = nack_r;

	dsh_spi_master u_spi (
		.i_clk_sys   (i_clk_sys),
		.i_nrst      (i_nrst),
		.cmd         (spi_cmd),
		.i_miso_sync (miso_q),
		.o_sclk      (o_ctrl_bit_clock),
		.o_sel_n     (o_ctrl_select_n),
		.o_mosi      (o_ctrl_serial_in)
	);

	// two-wire master, quarter-bit sequencing
	dsh_i2c_st_t ist_r;
	dsh_i2c_st_t ist_nxt;
	logic [7:0]  tc_r;
	logic [1:0]  q_r;
	logic [3:0]  bit_r;
	logic [1:0]  step_r;
	logic [1:0]  step_nxt;
	logic [7:0]  sh_r;
	logic        scl_low_r;
	logic        sda_low_r;
	logic        ack_r;

	// fast-mode bit rate from the quarter count
	wire tick     = (tc_r == I2C_QTR_M1);
	wire [6:0] dev_addr = {I2C_ADDR_HI, i_dev_sel};
	wire rx_byte  = rd_r & (step_r == 2'h3);
	wire ack_bit  = (bit_r == I2C_ACK_BIT);
	wire last_stp = rd_r ? (step_r == 2'h3) : (step_r == 2'h2);
	// a tx byte left unacknowledged ends the access
	wire bad_ack  = ~rx_byte & ack_r;
	// hold the high quarter while a slave stretches the clock
	wire stretch  = (ist_r == I2C_BIT) & (q_r == 2'h2) & ~scl_q;
	wire step_end = (ist_r == I2C_BIT) & tick & (q_r == 2'h3) & ack_bit;
	wire [7:0] next_b = i2c_byte(step_nxt, rd_r, dev_addr, {1'b0, addr_r},
		wdata_r);

	assign i2c_busy = (ist_r != I2C_IDLE);

	always_comb begin
		ist_nxt  = ist_r;
		step_nxt = step_r;
		case (ist_r)
			I2C_IDLE: begin
				step_nxt = 2'h0;
				if (take_i2c) begin
					ist_nxt = I2C_START;
				end
			end
			I2C_START: begin
				if (tick && q_r == 2'h3) begin
					ist_nxt = I2C_BIT;
				end
			end
			I2C_BIT: begin
				if (step_end) begin
					if (bad_ack || last_stp) begin
						ist_nxt = I2C_STOP;
					end else if (rd_r && step_r == 2'h1) begin
						ist_nxt  = I2C_RSTART;
						step_nxt = 2'h2;
					end else begin
						step_nxt = step_r + 2'h1;
					end
				end
			end
			I2C_RSTART: begin
				if (tick && q_r == 2'h3) begin
					ist_nxt = I2C_BIT;
				end
			end
			I2C_STOP: begin
				if (tick && q_r == 2'h3) begin
					ist_nxt = I2C_DONE;
				end
			end
			I2C_DONE: begin
				ist_nxt = I2C_IDLE;
			end
			default: begin
				ist_nxt = I2C_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ist_r  <= I2C_IDLE;
			step_r <= 2'h0;
			tc_r   <= 8'h00;
			q_r    <= 2'h0;
		end else begin
			ist_r  <= ist_nxt;
			step_r <= step_nxt;
			if (ist_r == I2C_IDLE || tick || stretch) begin
				tc_r <= 8'h00;
			end else begin
				tc_r <= tc_r + 8'h01;
			end
			if (ist_nxt != ist_r || ist_r == I2C_IDLE) begin
				q_r <= 2'h0;
			end else if (tick) begin
				q_r <= q_r + 2'h1;
			end
		end
	end

	// bit and byte datapath
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			bit_r      <= 4'h0;
			sh_r       <= 8'hff;
			i2c_rx_r   <= 8'h00;
			ack_r      <= 1'b0;
			i2c_nack_r <= 1'b0;
			i2c_done_r <= 1'b0;
		end else begin
			i2c_done_r <= (ist_r == I2C_DONE);
			if (take_i2c) begin
				sh_r       <= i2c_byte(2'h0, i_rd, dev_addr, {1'b0, i_addr},
					i_wdata);
				bit_r      <= 4'h0;
				i2c_nack_r <= 1'b0;
			end else if (step_end) begin
				sh_r  <= next_b;
				bit_r <= 4'h0;
				if (bad_ack) begin
					i2c_nack_r <= 1'b1;
				end
			end else if (ist_r == I2C_BIT && tick && !stretch) begin
				if (q_r == 2'h2) begin
					if (ack_bit) begin
						ack_r <= sda_q;
					end else begin
						sh_r <= {sh_r[6:0], 1'b1};
						if (rx_byte) begin
							i2c_rx_r <= {i2c_rx_r[6:0], sda_q};
						end
					end
				end else if (q_r == 2'h3 && !ack_bit) begin
					bit_r <= bit_r + 4'h1;
				end
			end
		end
	end

	// pin drive per quarter; drivers only ever pull low
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			scl_low_r <= 1'b0;
			sda_low_r <= 1'b0;
		end else if (tick) begin
			case (ist_r)
				I2C_START: begin
					sda_low_r <= (q_r != 2'h0);
					scl_low_r <= (q_r == 2'h2) || (q_r == 2'h3);
				end
				I2C_BIT: begin
					scl_low_r <= (q_r == 2'h3) || (q_r == 2'h0);
					if (q_r == 2'h0) begin
						// NACK after the read byte: line left high
						sda_low_r <= ~ack_bit & ~rx_byte & ~sh_r[7];
					end
				end
				I2C_RSTART: begin
					sda_low_r <= (q_r == 2'h2) || (q_r == 2'h3);
					scl_low_r <= (q_r == 2'h0) || (q_r == 2'h3);
				end
				I2C_STOP: begin
					sda_low_r <= (q_r == 2'h0) || (q_r == 2'h1);
					scl_low_r <= (q_r == 2'h0);
				end
				default: begin
					scl_low_r <= 1'b0;
					sda_low_r <= 1'b0;
				end
			endcase
		end else if (ist_r == I2C_IDLE) begin
			scl_low_r <= 1'b0;
			sda_low_r <= 1'b0;
		end
	end

	assign o_scl      = 1'b0;
	assign o_sda      = 1'b0;
	assign o_scl_oe_n = ~scl_low_r;
	assign o_sda_oe_n = ~sda_low_r;
endmodule

// ==== verification/dsh_host_asserts.sv ====
// Purpose: port-level protocol checks for the host control port
// Assumes: single clock domain, asynchronous active-low reset
// Notes:   bound into dsh_host
module dsh_host_chk (
	// clock, reset, command
	input wire logic i_clk_sys, i_nrst, i_req, i_rd, o_ready, o_done,
	// mode strap and four-wire pins
	input wire logic o_mode_strap, o_ctrl_bit_clock, o_ctrl_select_n,
	input wire logic o_ctrl_serial_in,
	// interrupt pass-through
	input wire logic i_error_or_irq_a_pin, o_irq_channel_a
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       rd_r;
	logic [4:0] edges_r;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	// direction of the accepted request, rising bit-clock edges per frame
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			rd_r    <= 1'b0;
			edges_r <= 5'h0;
		end else begin
			if (i_req && o_ready) rd_r <= i_rd;
			if (o_ctrl_select_n) edges_r <= 5'h0;
			else if ($rose(o_ctrl_bit_clock)) edges_r <= edges_r + 5'h1;
		end
	end
	sequence s_open; $fell(o_ctrl_select_n); endsequence
	sequence s_close; $rose(o_ctrl_select_n); endsequence
	property p_mode_spi; !o_mode_strap |-> o_ctrl_select_n; endproperty
	a_mode_spi: assert property (p_mode_spi)
		else $error("select low in two-wire mode");
	property p_strap; o_ready |=> $stable(o_mode_strap); endproperty
	a_strap: assert property (p_strap)
		else $error("mode strap moved after capture");
	property p_clk_idle; o_ctrl_select_n |-> o_ctrl_bit_clock; endproperty
	a_clk_idle: assert property (p_clk_idle)
		else $error("bit clock low while deselected");
	property p_dir; s_open |-> o_ctrl_serial_in == rd_r; endproperty
	a_dir: assert property (p_dir)
		else $error("first bit is not the direction");
	property p_len; s_close |-> edges_r == 5'h10; endproperty
	a_len: assert property (p_len)
		else $error("frame not sixteen clocks");
	// done pulse is launched with the select release
	property p_latch; s_close |-> o_done; endproperty
	a_latch: assert property (p_latch)
		else $error("no done after select release");
	property p_mosi;
		o_ctrl_bit_clock && $past(o_ctrl_bit_clock) && !o_ctrl_select_n &&
			!$past(o_ctrl_select_n) && edges_r != 5'h10
			|-> $stable(o_ctrl_serial_in);
	endproperty
	a_mosi: assert property (p_mosi)
		else $error("data changed while bit clock high");
	property p_irq;
		$stable(i_error_or_irq_a_pin) [*3]
			|-> o_irq_channel_a == i_error_or_irq_a_pin;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt level not passed on");
endmodule
bind dsh_host dsh_host_chk u_chk (.i_clk_sys, .i_nrst, .i_req, .i_rd,
	.o_ready, .o_done, .o_mode_strap, .o_ctrl_bit_clock, .o_ctrl_select_n,
	.o_ctrl_serial_in, .i_error_or_irq_a_pin, .o_irq_channel_a);

// ==== verification/dsh_dev_model.sv ====
// Purpose: behavioural device behind both control ports
// Assumes: device reset released after the mode pin settles
// Notes:   two-wire register addresses below 20h count as undefined
module dsh_dev_model (
	// reset and straps
	input wire logic       i_nrst, i_mode,
	input wire logic [1:0] i_sel,
	input wire logic [7:0] i_cs,
	// four-wire
	input wire logic       i_sck, i_sel_n, i_mosi,
	output logic           o_miso,
	// two-wire and interrupts
	input wire logic       i_scl, i_sda,
	output logic           o_sda_rel, o_irq_a, o_irq_b
);
	timeunit 1ns;
	timeprecision 1ps;
	import dsh_pkg::*;
	logic [7:0]  mem [128];
	logic [15:0] sh;
	logic [7:0]  od, b, idx, cs_r;
	logic [4:0]  cnt;
	logic        mode_r, oe, st_f, ok, fa, fb;
	initial begin
		for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'ha5;
		{cnt, oe, od, st_f, fa, fb, idx, o_sda_rel} = 26'h1;
		cs_r = 8'hff;
	end
	always @(i_nrst or i_mode) if (!i_nrst) mode_r = i_mode;
	always @(posedge i_sck or posedge i_sel_n) begin
		if (i_sel_n) begin
			if (cnt == 5'h10 && !sh[15]) mem[sh[14:8]] = sh[7:0];
			cnt = 5'h0;
			// last read bit stands until select returns high
			oe = 1'b0;
		end else if (mode_r == MODE_SPI) begin
			sh = {sh[14:0], i_mosi};
			cnt = cnt + 5'h1;
		end
	end
	always @(negedge i_sck) if (!i_sel_n && cnt >= 5'h8) begin
		if (cnt == 5'h8) {oe, od} = {sh[7], mem[sh[6:0]]};
		else od = {od[6:0], ~od[7]};
	end
	assign o_miso = oe ? od[7] : ~od[7];
	always @(i_cs or i_sel_n) if (i_sel_n && cs_r !== i_cs) begin
		cs_r = i_cs;
		mem[7'h5a] = i_cs;
		{fa, fb} = 2'h3;
	end
	assign o_irq_a = fa & mem[7'h2a][3];
	assign o_irq_b = fb & mem[7'h2b][3];
	task automatic rx;
		repeat (8) @(posedge i_scl) b = {b[6:0], i_sda};
	endtask
	task automatic ack(input logic a);
		@(negedge i_scl) #1 o_sda_rel = !a;
		@(negedge i_scl) #1 o_sda_rel = 1'b1;
	endtask
	always @(negedge i_sda) if (i_scl && mode_r != MODE_SPI) begin
		st_f = 1'b1;
		disable slave;
	end
	always begin : slave
		o_sda_rel = 1'b1;
		wait (st_f);
		st_f = 1'b0;
		rx();
		if (b[7:1] == {I2C_ADDR_HI, i_sel}) begin
			if (b[0]) begin
				@(negedge i_scl) #1 o_sda_rel = 1'b0;
				for (int i = 7; i >= 0; i--)
					@(negedge i_scl) #1 o_sda_rel = mem[idx[6:0]][i];
				@(negedge i_scl) #1 o_sda_rel = 1'b1;
			end else begin
				ack(1'b1);
				rx();
				idx = b;
				ok = idx >= 8'h20 && idx < 8'h80;
				ack(ok);
				while (ok) begin
					rx();
					mem[idx[6:0]] = b;
					idx = idx + 8'h1;
					ack(1'b1);
				end
			end
		end
	end
endmodule

// ==== verification/dsh_host_tb.sv ====
// Purpose: self-checking bench for the host control port
// Assumes: device model answers on both ports
// Notes:   four-wire pass first, then a reset into two-wire mode
module dsh_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk_sys = 1'b0, i_nrst = 1'b0, dev_nrst = 1'b0;
	logic        i_mode_spi = 1'b1, i_req = 1'b0, i_rd = 1'b0;
	logic [1:0]  i_dev_sel = 2'h2;
	logic [6:0]  i_addr = 7'h0, a;
	logic [7:0]  i_wdata = 8'h0, cs = 8'hff, shadow [128];
	logic [31:0] seed = 32'h5990;
	int          error_cnt = 0, comparisons = 0;
	wire         o_mode_strap, o_ready, o_done, o_nack, sck, sel_n, mosi;
	wire         miso, scl_oe_n, sda_oe_n, sda_rel, irq_a, irq_b;
	wire         irq_a_o, irq_b_o;
	wire [7:0]   o_rdata;
	wire         scl = scl_oe_n;
	wire         sda = sda_oe_n & sda_rel;
	always #5 i_clk_sys = ~i_clk_sys;
	dsh_host dut (.i_clk_sys, .i_nrst, .i_mode_spi, .i_dev_sel,
		.o_mode_strap, .i_req, .i_rd, .i_addr, .i_wdata, .o_ready, .o_done,
		.o_rdata, .o_nack, .o_ctrl_bit_clock(sck), .o_ctrl_select_n(sel_n),
		.o_ctrl_serial_in(mosi), .i_ctrl_serial_out(miso), .i_scl(scl),
		.o_scl(), .o_scl_oe_n(scl_oe_n), .i_sda(sda), .o_sda(),
		.o_sda_oe_n(sda_oe_n), .i_error_or_irq_a_pin(irq_a),
		.i_nonlinear_or_irq_b_pin(irq_b), .o_irq_channel_a(irq_a_o),
		.o_irq_channel_b(irq_b_o));
	dsh_dev_model u_dev (.i_nrst(dev_nrst), .i_mode(o_mode_strap),
		.i_sel(2'h2), .i_cs(cs), .i_sck(sck), .i_sel_n(sel_n),
		.i_mosi(mosi), .o_miso(miso), .i_scl(scl), .i_sda(sda),
		.o_sda_rel(sda_rel), .o_irq_a(irq_a), .o_irq_b(irq_b));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	// model answers select 2 only, registers below 20h undefined
	function automatic logic [7:0] exp_nack(input logic [1:0] s,
		input logic [6:0] ad);
		return {7'h0, s != 2'h2 || ad < 7'h20};
	endfunction
	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic r, input logic [6:0] ad, input logic [7:0] d);
		int n;
		n = 0;
		while (o_ready !== 1'b1) @(negedge i_clk_sys);
		{i_req, i_rd, i_addr, i_wdata} = {1'b1, r, ad, d};
		@(negedge i_clk_sys);
		i_req = 1'b0;
		while (o_done !== 1'b1 && n < 20000) begin
			@(negedge i_clk_sys);
			n++;
		end
		if (n == 20000) begin
			chk(8'h0, 8'h1);
			give_verdict();
		end
		// read data and nack are registered one cycle after done
		@(negedge i_clk_sys);
	endtask
	task automatic rst(input logic m);
		{i_nrst, dev_nrst, i_mode_spi} = {2'b00, m};
		repeat (8) @(negedge i_clk_sys);
		i_nrst = 1'b1;
		repeat (3) @(negedge i_clk_sys);
		dev_nrst = 1'b1;
	endtask
	initial begin
		#900_000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		for (int i = 0; i < 128; i++) shadow[i] = 8'(i) ^ 8'ha5;
		rst(1'b1);
		chk({7'h0, o_mode_strap}, 8'h1);
		for (int k = 0; k < 14; k++) begin
			seed = xs(seed);
			a = k < 2 ? {7{k[0]}} : seed[6:0];
			acc(1'b0, a, seed[15:8]);
			shadow[a] = seed[15:8];
			acc(1'b1, a, 8'h0);
			chk(o_rdata, shadow[a]);
		end
		i_mode_spi = 1'b0;
		acc(1'b0, 7'h2a, 8'h08);
		acc(1'b0, 7'h2b, 8'h08);
		chk({7'h0, o_mode_strap}, 8'h1);
		cs = 8'h3c;
		repeat (6) @(negedge i_clk_sys);
		chk({7'h0, irq_a_o}, 8'h1);
		chk({7'h0, irq_b_o}, 8'h1);
		// status changes mid-frame; the read must see the frozen value
		fork
			acc(1'b1, 7'h5a, 8'h0);
			begin
				repeat (100) @(negedge i_clk_sys);
				cs = 8'hc3;
			end
		join
		chk(o_rdata, 8'h3c);
		acc(1'b1, 7'h5a, 8'h0);
		chk(o_rdata, 8'hc3);
		acc(1'b0, 7'h2a, 8'h00);
		repeat (6) @(negedge i_clk_sys);
		chk({7'h0, irq_a_o}, 8'h0);
		chk({7'h0, irq_b_o}, 8'h1);
		rst(1'b0);
		chk({7'h0, o_mode_strap}, 8'h0);
		for (int s = 0; s < 4; s++) begin
			i_dev_sel = 2'(s);
			acc(1'b0, 7'h30, 8'h64);
			chk({7'h0, o_nack}, exp_nack(2'(s), 7'h30));
		end
		i_dev_sel = 2'h2;
		shadow[7'h30] = 8'h64;
		acc(1'b0, 7'h05, 8'h11);
		chk({7'h0, o_nack}, exp_nack(i_dev_sel, 7'h05));
		for (int k = 0; k < 3; k++) begin
			seed = xs(seed);
			a = k == 0 ? 7'h30 : 7'h20 | seed[6:0];
			if (k > 0) acc(1'b0, a, seed[15:8]);
			if (k > 0) shadow[a] = seed[15:8];
			acc(1'b1, a, 8'h0);
			chk(o_rdata, shadow[a]);
			chk({7'h0, o_nack}, 8'h0);
		end
		give_verdict();
	end
endmodule
